// ===== hdl/estc_consts.vh
// constants for the exposure start trigger controller
`ifndef ESTC_CONSTS_VH
`define ESTC_CONSTS_VH
// register byte offsets
`define ESTC_REG_CTRL 8'h00
`define ESTC_REG_CMD 8'h04
`define ESTC_REG_EXPOSURE 8'h08
`define ESTC_REG_PERIOD 8'h0c
`define ESTC_REG_MINPERIOD 8'h10
`define ESTC_REG_FRAMECOUNT 8'h14
`define ESTC_REG_STATUS 8'h18
`define ESTC_REG_FRAMES 8'h1c
// control field positions
`define ESTC_CTRL_TRIG_ON 0
`define ESTC_CTRL_SRC_LO 1
`define ESTC_CTRL_SRC_HI 3
`define ESTC_CTRL_RISING 4
`define ESTC_CTRL_WIDTH 5
`define ESTC_CTRL_ACQ_LO 6
`define ESTC_CTRL_ACQ_HI 7
`define ESTC_CTRL_USEROUT 8
`define ESTC_CTRL_TMR_LEVEL 9
// command bits
`define ESTC_CMD_START 0
`define ESTC_CMD_STOP 1
`define ESTC_CMD_SWTRIG 2
// trigger sources
`define ESTC_SRC_SOFTWARE 3'd0
`define ESTC_SRC_USEROUT 3'd1
`define ESTC_SRC_GRABBER 3'd2
`define ESTC_SRC_TIMER 3'd3
`define ESTC_SRC_LINE 3'd4
// acquisition modes
`define ESTC_ACQ_CONTINUOUS 2'd0
`define ESTC_ACQ_ONE 2'd1
`define ESTC_ACQ_COUNTED 2'd2
// reset values
`define ESTC_CTRL_RESET 10'h011
`define ESTC_EXPOSURE_RESET 32'h000000fa
`define ESTC_PERIOD_RESET 32'h00000fa0
`define ESTC_MINPERIOD_RESET 32'h000003e8
`define ESTC_FRAMECOUNT_RESET 16'h0001
`endif

// ===== hdl/estc_edge_sync.v
// two-flop synchroniser with polarity-selectable edge detector
`timescale 1ns/100ps
`default_nettype none
module estc_edge_sync
(
	input wire clk,
	input wire srst,
	input wire ce,
	input wire async_in,
	input wire rising,
	output wire level,
	output wire edge_pulse
);
	reg meta;
	reg sync;
	reg prev;
	// first flop feeds only the second one
	always @(posedge clk)
	begin
		if (srst)
		begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end
		else if (ce)
		begin
			meta <= async_in;
			sync <= meta;
			prev <= sync;
		end
	end
	// active level follows the chosen polarity so width mode can use it directly
	assign level = rising ? sync : ~sync;
	// one pulse per qualifying edge
	assign edge_pulse = ce & (rising ? (sync & ~prev) : (~sync & prev));
endmodule // estc_edge_sync
`default_nettype wire

// ===== hdl/estc_trigger_ctrl.v
// exposure start trigger controller with AHB-Lite register slave
// Notes on behaviour
// - only one trigger type exists: exposure start, beginning a frame.
// - trigger off: internal triggers from start command until stop command.
// - free run period is programmed period or minimum period, whichever longer.
// - trigger off: exposure length is the programmed exposure time.
// - trigger on: frames start only from the selected source.
// - activation picks rising or falling edge as the trigger.
// - software source always uses programmed exposure time.
// - grabber or line source: timed uses exposure time, width follows signal.
// - timer source width mode: edge timer duration, or level timer follows the input line.
// - user output source width mode: exposure lasts while bit stays at its active level.
// - accepted trigger leaves waiting; return automatically when ready again.
// - software triggers outside waiting are discarded.
// - grabber edges during an exposure are discarded.
// - line source uses the input connector signal with configured polarity.
// - under line control frame rate equals one over trigger period.
// - acquisition mode: continuous, one frame, or counted frames then stop.
`timescale 1ns/100ps
`default_nettype none
`include "estc_consts.vh"
module estc_trigger_ctrl
(
	input wire CORE_CLK,
	input wire SRST,
	input wire CLK_EN,
	input wire HSEL,
	input wire [31:0] HADDR,
	input wire [1:0] HTRANS,
	input wire HWRITE,
	input wire [2:0] HSIZE,
	input wire [31:0] HWDATA,
	input wire HREADY,
	output reg [31:0] HRDATA,
	output reg HREADYOUT,
	output reg HRESP,
	input wire GRABBER_LINE,
	input wire HW_INPUT_LINE,
	input wire TIMER_OUTPUT,
	input wire READOUT_BUSY,
	output reg EXPOSURE_ACTIVE,
	output reg FRAME_START,
	output reg WAITING_FOR_TRIGGER,
	output reg ACQUISITION_ACTIVE
);
	// ****************************************
	// state encoding
	// ****************************************
	localparam ST_IDLE = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_EXPOSE = 3'b100;

	reg [9:0] ctrl;
	reg [31:0] exposure_time;
	reg [31:0] frame_period;
	reg [31:0] min_period;
	reg [15:0] frame_count;
	reg [15:0] frames_done;
	reg [2:0] state;
	reg [31:0] expo_cnt;
	reg [31:0] period_cnt;
	reg width_exposure;
	reg stop_pending;
	reg dp_write;
	reg dp_read;
	reg [7:0] dp_addr;
	reg start_cmd;
	reg stop_cmd;
	reg sw_trig;

	wire trig_on = ctrl[`ESTC_CTRL_TRIG_ON];
	wire [2:0] src = ctrl[`ESTC_CTRL_SRC_HI:`ESTC_CTRL_SRC_LO];
	wire rising = ctrl[`ESTC_CTRL_RISING];
	wire width_mode = ctrl[`ESTC_CTRL_WIDTH];
	wire [1:0] acq_mode = ctrl[`ESTC_CTRL_ACQ_HI:`ESTC_CTRL_ACQ_LO];
	wire user_output_bit_source = ctrl[`ESTC_CTRL_USEROUT];
	wire timer_level = ctrl[`ESTC_CTRL_TMR_LEVEL];

	// ****************************************
	// input synchronisers and edge detectors
	// ****************************************
	wire grab_lvl;
	wire grab_edge;
	wire line_lvl;
	wire line_edge;
	wire tmr_lvl;
	wire tmr_edge;
	wire rd_lvl;
	wire user_edge;
	wire user_lvl;
	reg user_prev;

	estc_edge_sync u_grab (.clk(CORE_CLK), .srst(SRST), .ce(CLK_EN), .async_in(GRABBER_LINE),
		.rising(rising), .level(grab_lvl), .edge_pulse(grab_edge));
	// hardware_input_line_source: connector signal with configured polarity
	estc_edge_sync u_line (.clk(CORE_CLK), .srst(SRST), .ce(CLK_EN), .async_in(HW_INPUT_LINE),
		.rising(rising), .level(line_lvl), .edge_pulse(line_edge));
	// timer_output_source: high while the timer output is active
	estc_edge_sync u_tmr (.clk(CORE_CLK), .srst(SRST), .ce(CLK_EN), .async_in(TIMER_OUTPUT),
		.rising(rising), .level(tmr_lvl), .edge_pulse(tmr_edge));
	estc_edge_sync u_rd (.clk(CORE_CLK), .srst(SRST), .ce(CLK_EN), .async_in(READOUT_BUSY),
		.rising(1'b1), .level(rd_lvl), .edge_pulse());

	// user output bit is a register on this clock, so no synchroniser is needed
	always @(posedge CORE_CLK)
	begin
		if (SRST)
			user_prev <= 1'b0;
		else if (CLK_EN)
			user_prev <= user_output_bit_source;
	end
	// on creates a rising edge, off a falling edge
	assign user_lvl = rising ? user_output_bit_source : ~user_output_bit_source;
	assign user_edge = CLK_EN & (rising ? (user_output_bit_source & ~user_prev)
		: (~user_output_bit_source & user_prev));

	// ****************************************
	// source selection
	// ****************************************
	reg sel_edge;
	reg sel_level;
	reg sel_width;
	// only the selected source can start a frame
	always @*
	begin
		sel_edge = 1'b0;
		sel_level = 1'b0;
		sel_width = 1'b0;
		if (src == `ESTC_SRC_SOFTWARE)
		begin
			sel_edge = sw_trig;
			sel_width = 1'b0;
		end
		else if (src == `ESTC_SRC_USEROUT)
		begin
			sel_edge = user_edge;
			sel_level = user_lvl;
			sel_width = width_mode;
		end
		else if (src == `ESTC_SRC_GRABBER)
		begin
			sel_edge = grab_edge;
			sel_level = grab_lvl;
			sel_width = width_mode;
		end
		else if (src == `ESTC_SRC_TIMER)
		begin
			// edge-activated timer: its output pulse is the duration; level timer tracks the input line level
			sel_edge = tmr_edge;
			sel_level = timer_level ? line_lvl : tmr_lvl;
			sel_width = width_mode;
		end
		else if (src == `ESTC_SRC_LINE)
		begin
			sel_edge = line_edge;
			sel_level = line_lvl;
			sel_width = width_mode;
		end
	end

	// ****************************************
	// free-run rate limit
	// ****************************************
	// slower of programmed and minimum period wins
	wire [31:0] run_period = (frame_period > min_period) ? frame_period : min_period;
	wire free_fire = (period_cnt == 32'h00000000);
	// internal trigger in free run, edge of the selected source otherwise
	wire trig_event = trig_on ? sel_edge : free_fire;
	wire can_start = ~rd_lvl | (state == ST_WAIT);
	wire last_frame = (acq_mode == `ESTC_ACQ_ONE) ||
		((acq_mode == `ESTC_ACQ_COUNTED) && (frames_done + 16'h0001 >= frame_count));

	// ****************************************
	// acquisition state machine
	// ****************************************
	always @(posedge CORE_CLK)
	begin
		if (SRST)
		begin
			state <= ST_IDLE;
			expo_cnt <= 32'h00000000;
			period_cnt <= 32'h00000000;
			width_exposure <= 1'b0;
			stop_pending <= 1'b0;
			frames_done <= 16'h0000;
			EXPOSURE_ACTIVE <= 1'b0;
			FRAME_START <= 1'b0;
			WAITING_FOR_TRIGGER <= 1'b0;
			ACQUISITION_ACTIVE <= 1'b0;
		end
		else if (CLK_EN)
		begin
			FRAME_START <= 1'b0;
			if (period_cnt != 32'h00000000)
				period_cnt <= period_cnt - 32'h00000001;
			case (state)
			ST_IDLE:
			begin
				if (start_cmd)
				begin
					state <= ST_WAIT;
					frames_done <= 16'h0000;
					stop_pending <= 1'b0;
					period_cnt <= 32'h00000000;
					WAITING_FOR_TRIGGER <= 1'b1;
					ACQUISITION_ACTIVE <= 1'b1;
				end
			end
			ST_WAIT:
			begin
				if (stop_cmd)
				begin
					state <= ST_IDLE;
					WAITING_FOR_TRIGGER <= 1'b0;
					ACQUISITION_ACTIVE <= 1'b0;
				end
				else if (trig_event && can_start)
				begin
					// accepted trigger leaves waiting
					state <= ST_EXPOSE;
					WAITING_FOR_TRIGGER <= 1'b0;
					EXPOSURE_ACTIVE <= 1'b1;
					FRAME_START <= 1'b1;
					// programmed exposure unless width mode with trigger on and a source other than software
					width_exposure <= trig_on & sel_width;
					expo_cnt <= exposure_time;
					period_cnt <= run_period - 32'h00000001;
					stop_pending <= last_frame;
					frames_done <= frames_done + 16'h0001;
				end
			end
			ST_EXPOSE:
			begin
				// triggers during exposure fall through unused
				if (stop_cmd)
					stop_pending <= 1'b1;
				if (width_exposure ? ~sel_level : (expo_cnt <= 32'h00000001))
				begin
					EXPOSURE_ACTIVE <= 1'b0;
					// one-frame and counted modes stop themselves
					if (stop_pending || stop_cmd)
					begin
						state <= ST_IDLE;
						ACQUISITION_ACTIVE <= 1'b0;
					end
					else
					begin
						state <= ST_WAIT;
						WAITING_FOR_TRIGGER <= 1'b1;
					end
				end
				else
					expo_cnt <= expo_cnt - 32'h00000001;
			end
			default:
				state <= ST_IDLE;
			endcase
		end
	end

	// ****************************************
	// AHB-Lite slave
	// ****************************************
	wire take = HSEL & HREADY & HTRANS[1];
	wire [31:0] status_word = {27'h0000000, rd_lvl, EXPOSURE_ACTIVE, WAITING_FOR_TRIGGER,
		ACQUISITION_ACTIVE, state[0]};

	// address phase captured; data phase answers in the next cycle with zero wait
	always @(posedge CORE_CLK)
	begin
		if (SRST)
		begin
			dp_write <= 1'b0;
			dp_read <= 1'b0;
			dp_addr <= 8'h00;
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
		else if (CLK_EN)
		begin
			dp_write <= take & HWRITE;
			dp_read <= take & ~HWRITE;
			if (take)
				dp_addr <= {HADDR[7:2], 2'b00};
		end
	end

	// register writes and read mux; unmapped reads return zero, writes are dropped
	always @(posedge CORE_CLK)
	begin
		if (SRST)
		begin
			ctrl <= `ESTC_CTRL_RESET;
			exposure_time <= `ESTC_EXPOSURE_RESET;
			frame_period <= `ESTC_PERIOD_RESET;
			min_period <= `ESTC_MINPERIOD_RESET;
			frame_count <= `ESTC_FRAMECOUNT_RESET;
			start_cmd <= 1'b0;
			stop_cmd <= 1'b0;
			sw_trig <= 1'b0;
			HRDATA <= 32'h00000000;
		end
		else if (CLK_EN)
		begin
			start_cmd <= 1'b0;
			stop_cmd <= 1'b0;
			sw_trig <= 1'b0;
			if (dp_write)
			begin
				if (dp_addr == `ESTC_REG_CTRL)
					ctrl <= HWDATA[9:0];
				else if (dp_addr == `ESTC_REG_CMD)
				begin
					start_cmd <= HWDATA[`ESTC_CMD_START];
					stop_cmd <= HWDATA[`ESTC_CMD_STOP];
					sw_trig <= HWDATA[`ESTC_CMD_SWTRIG] & trig_on;
				end
				else if (dp_addr == `ESTC_REG_EXPOSURE)
					exposure_time <= HWDATA;
				else if (dp_addr == `ESTC_REG_PERIOD)
					frame_period <= HWDATA;
				else if (dp_addr == `ESTC_REG_MINPERIOD)
					min_period <= HWDATA;
				else if (dp_addr == `ESTC_REG_FRAMECOUNT)
					frame_count <= HWDATA[15:0];
			end
			if (take & ~HWRITE)
			begin
				if (HADDR[7:0] == `ESTC_REG_CTRL)
					HRDATA <= {22'h000000, ctrl};
				else if (HADDR[7:0] == `ESTC_REG_EXPOSURE)
					HRDATA <= exposure_time;
				else if (HADDR[7:0] == `ESTC_REG_PERIOD)
					HRDATA <= frame_period;
				else if (HADDR[7:0] == `ESTC_REG_MINPERIOD)
					HRDATA <= min_period;
				else if (HADDR[7:0] == `ESTC_REG_FRAMECOUNT)
					HRDATA <= {16'h0000, frame_count};
				else if (HADDR[7:0] == `ESTC_REG_STATUS)
					HRDATA <= status_word;
				else if (HADDR[7:0] == `ESTC_REG_FRAMES)
					HRDATA <= {16'h0000, frames_done};
				else
					HRDATA <= 32'h00000000;
			end
		end
	end
endmodule // estc_trigger_ctrl
`default_nettype wire

// ===== testbench/estc_props.sv
// port-level assertion checker for the exposure start trigger controller
`timescale 1ns/100ps
`default_nettype none
module estc_props
(
	input wire logic CORE_CLK,
	input wire logic SRST,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic EXPOSURE_ACTIVE,
	input wire logic FRAME_START,
	input wire logic WAITING_FOR_TRIGGER,
	input wire logic ACQUISITION_ACTIVE
);
	// ****
	// frame start, status, reset and bus relations
	// ****
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (SRST);
	// the start pulse and the rise of exposure must coincide
	sequence s_opens;
		FRAME_START ##0 $rose(EXPOSURE_ACTIVE);
	endsequence
	chk_bus_okay: assert property (HREADYOUT && !HRESP)
		else $error("bus slave not ready or not okay");
	chk_start_pulse: assert property (FRAME_START |=> !FRAME_START)
		else $error("frame start longer than one cycle");
	chk_start_opens: assert property (FRAME_START |-> s_opens)
		else $error("frame start without a new exposure");
	chk_start_waited: assert property (FRAME_START |-> $past(WAITING_FOR_TRIGGER))
		else $error("frame start while not waiting");
	chk_rise_marked: assert property ($rose(EXPOSURE_ACTIVE) |-> FRAME_START)
		else $error("exposure began without a frame start");
	chk_busy_not_wait: assert property (EXPOSURE_ACTIVE |-> !WAITING_FOR_TRIGGER)
		else $error("waiting while exposing");
	chk_wait_in_acq: assert property (WAITING_FOR_TRIGGER |-> ACQUISITION_ACTIVE)
		else $error("waiting outside an acquisition");
	// only the first sampled edge after release still shows the reset state
	chk_reset_quiet: assert property ($fell(SRST) |-> !(EXPOSURE_ACTIVE || FRAME_START || WAITING_FOR_TRIGGER
		|| ACQUISITION_ACTIVE))
		else $error("outputs active straight after reset");
endmodule // estc_props
bind estc_trigger_ctrl estc_props i_props (.CORE_CLK(CORE_CLK), .SRST(SRST), .HREADYOUT(HREADYOUT),
	.HRESP(HRESP), .EXPOSURE_ACTIVE(EXPOSURE_ACTIVE), .FRAME_START(FRAME_START),
	.WAITING_FOR_TRIGGER(WAITING_FOR_TRIGGER), .ACQUISITION_ACTIVE(ACQUISITION_ACTIVE));
`default_nettype wire

// ===== testbench/estc_trig_source.sv
// far-side model driving the external trigger pins
`timescale 1ns/100ps
`default_nettype none
module estc_trig_source
(
	input wire logic clk,
	output var logic grabber_line,
	output var logic hw_input_line,
	output var logic timer_output,
	output var logic readout_busy
);
	// idle levels; readout stays quiet because the block ignores it while waiting
	initial
	begin
		grabber_line = 1'b0;
		hw_input_line = 1'b0;
		timer_output = 1'b0;
		readout_busy = 1'b0;
	end
	// one pulse on a pin (0 grabber, 1 line, other timer), then a quiet gap
	task automatic pulse(input int sel, input logic lvl, input int hi, input int lo);
		@(posedge clk);
		set_pin(sel, lvl);
		repeat (hi) @(posedge clk);
		set_pin(sel, !lvl);
		repeat (lo) @(posedge clk);
	endtask
	task automatic set_pin(input int sel, input logic v);
		case (sel)
			0: grabber_line <= v;
			1: hw_input_line <= v;
			default: timer_output <= v;
		endcase
	endtask
endmodule // estc_trig_source
`default_nettype wire

// ===== testbench/exposure_start_trigger_ctrl_bench.sv
// self-checking bench for the exposure start trigger controller
`timescale 1ns/100ps
`default_nettype none
`include "estc_consts.vh"
module exposure_start_trigger_ctrl_bench;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic clk_en = 1'b1;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	wire [31:0] hrdata;
	wire rdy, resp, grab, line, tmr, busy, expo, fst, waiting, acq;
	int failures = 0;
	int checks = 0;
	// 250 MHz core clock
	always #2 clk = ~clk;
	estc_trigger_ctrl i_dut (.CORE_CLK(clk), .SRST(srst), .CLK_EN(clk_en), .HSEL(1'b1), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(rdy), .HRDATA(hrdata),
		.HREADYOUT(rdy), .HRESP(resp), .GRABBER_LINE(grab), .HW_INPUT_LINE(line), .TIMER_OUTPUT(tmr),
		.READOUT_BUSY(busy), .EXPOSURE_ACTIVE(expo), .FRAME_START(fst), .WAITING_FOR_TRIGGER(waiting),
		.ACQUISITION_ACTIVE(acq));
	estc_trig_source i_src (.clk(clk), .grabber_line(grab), .hw_input_line(line), .timer_output(tmr),
		.readout_busy(busy));
	// ****
	// shared tasks
	// ****
	task automatic end_of_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	// sample a little after the edge so registered outputs have settled
	task automatic tick();
		@(posedge clk);
		#1;
	endtask
	// the slave holds HREADYOUT high with zero wait; a bounded wait still keeps a hang from stalling the run
	task automatic wait_ready();
		int n;
		n = 0;
		@(posedge clk);
		while (rdy !== 1'b1)
		begin
			n++;
			if (n > 100)
			begin
				failures++;
				end_of_test();
			end
			@(posedge clk);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd_check(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		compare(what, exp, r);
	endtask
	// cycles until the next frame start, bounded
	task automatic wait_frame(output int n);
		n = 0;
		do
		begin
			tick();
			n++;
			if (n > 5000)
			begin
				failures++;
				end_of_test();
			end
		end
		while (fst !== 1'b1);
	endtask
	task automatic expo_len(output int len);
		len = 0;
		while (expo === 1'b1)
		begin
			len++;
			tick();
			if (len > 5000)
			begin
				failures++;
				end_of_test();
			end
		end
	endtask
	task automatic count_frames(input int cycles, output int f);
		f = 0;
		repeat (cycles)
		begin
			tick();
			f = f + int'(fst === 1'b1);
		end
	endtask
	task automatic start_acq(input logic [31:0] ctrl);
		wr(`ESTC_REG_CTRL, ctrl);
		wr(`ESTC_REG_CMD, 32'h1);
	endtask
	task automatic stop_acq();
		int f;
		wr(`ESTC_REG_CMD, 32'h2);
		count_frames(300, f);
		compare("acquisition after stop", 32'h0, {31'h0, acq});
	endtask
	// ****
	// scenarios
	// ****
	task automatic s_registers();
		rd_check("ctrl", `ESTC_REG_CTRL, 32'h11);
		rd_check("exposure", `ESTC_REG_EXPOSURE, 32'hfa);
		rd_check("period", `ESTC_REG_PERIOD, 32'hfa0);
		rd_check("min period", `ESTC_REG_MINPERIOD, 32'h3e8);
		rd_check("frame count", `ESTC_REG_FRAMECOUNT, 32'h1);
		rd_check("unmapped", 8'h40, 32'h0);
		rd_check("status idle", `ESTC_REG_STATUS, 32'h1);
	endtask
	task automatic s_free_run();
		int n;
		wr(`ESTC_REG_EXPOSURE, 32'd5);
		wr(`ESTC_REG_PERIOD, 32'd40);
		wr(`ESTC_REG_MINPERIOD, 32'd20);
		start_acq(32'h0);
		wait_frame(n);
		wait_frame(n);
		compare("free run gap", 32'd40, n);
		expo_len(n);
		compare("free run exposure", 32'd5, n);
		wr(`ESTC_REG_PERIOD, 32'd10);
		wait_frame(n);
		wait_frame(n);
		compare("rate limited gap", 32'd20, n);
		// a low clock enable freezes the period counter, stretching the gap by the frozen cycles
		@(posedge clk);
		clk_en <= 1'b0;
		repeat (7) @(posedge clk);
		clk_en <= 1'b1;
		wait_frame(n);
		compare("clock enable hold", 32'd27, n + 8);
		stop_acq();
	endtask
	task automatic s_modes();
		int f;
		wr(`ESTC_REG_FRAMECOUNT, 32'd3);
		start_acq(32'h40);
		count_frames(300, f);
		compare("one frame mode", 32'd1, f);
		start_acq(32'h80);
		count_frames(300, f);
		compare("counted mode", 32'd3, f);
		compare("acquisition ended", 32'h0, {31'h0, acq});
		rd_check("frames done", `ESTC_REG_FRAMES, 32'd3);
	endtask
	task automatic s_software();
		int n;
		int f;
		wr(`ESTC_REG_EXPOSURE, 32'd50);
		start_acq(32'h11);
		count_frames(100, f);
		compare("frames without trigger", 32'd0, f);
		compare("waiting for trigger", 32'h1, {31'h0, waiting});
		wr(`ESTC_REG_CMD, 32'h4);
		wait_frame(n);
		wr(`ESTC_REG_CMD, 32'h4);
		count_frames(100, f);
		compare("trigger while exposing", 32'd0, f);
		wr(`ESTC_REG_CTRL, 32'h31);
		wr(`ESTC_REG_CMD, 32'h4);
		wait_frame(n);
		expo_len(n);
		compare("software exposure", 32'd50, n);
		stop_acq();
	endtask
	task automatic s_line();
		int n;
		wr(`ESTC_REG_EXPOSURE, 32'd5);
		start_acq(32'h39);
		fork
			i_src.pulse(1, 1'b1, 12, 8);
			begin
				wait_frame(n);
				expo_len(n);
			end
		join
		compare("width exposure", 32'h1, 32'(n > 10 && n < 14));
		wr(`ESTC_REG_CTRL, 32'h19);
		fork
			repeat (3) i_src.pulse(1, 1'b1, 4, 25);
			begin
				wait_frame(n);
				wait_frame(n);
			end
		join
		compare("line frame gap", 32'd30, n);
		wr(`ESTC_REG_CTRL, 32'h09);
		fork
			i_src.pulse(1, 1'b1, 20, 20);
			wait_frame(n);
		join
		compare("falling edge only", 32'h1, 32'(n > 21));
		stop_acq();
	endtask
	task automatic s_others();
		int n;
		int f;
		wr(`ESTC_REG_EXPOSURE, 32'd50);
		start_acq(32'h15);
		fork
			repeat (2) i_src.pulse(0, 1'b1, 4, 10);
			count_frames(150, f);
		join
		compare("grabber frames", 32'd1, f);
		wr(`ESTC_REG_CTRL, 32'h17);
		fork
			i_src.pulse(2, 1'b1, 4, 10);
			begin
				wait_frame(n);
				expo_len(n);
			end
		join
		compare("timer exposure", 32'd50, n);
		// width mode with an edge-activated timer: the timer pulse sets the length
		wr(`ESTC_REG_CTRL, 32'h37);
		fork
			i_src.pulse(2, 1'b1, 10, 10);
			begin
				wait_frame(n);
				expo_len(n);
			end
		join
		compare("timer edge width", 32'd10, n);
		// level-activated timer: the timer starts the frame, the line level ends it
		wr(`ESTC_REG_CTRL, 32'h237);
		fork
			i_src.pulse(2, 1'b1, 4, 30);
			i_src.pulse(1, 1'b1, 16, 20);
			begin
				wait_frame(n);
				expo_len(n);
			end
		join
		compare("timer level width", 32'd16, n);
		wr(`ESTC_REG_CTRL, 32'h33);
		wr(`ESTC_REG_CTRL, 32'h133);
		wait_frame(n);
		repeat (60) tick();
		compare("user bit held", 32'h1, {31'h0, expo});
		wr(`ESTC_REG_CTRL, 32'h33);
		repeat (10) tick();
		compare("user bit released", 32'h0, {31'h0, expo});
		stop_acq();
	endtask
	// main sequence: reset for three cycles, then each scenario in turn
	initial
	begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		s_registers();
		s_free_run();
		s_modes();
		s_software();
		s_line();
		s_others();
		end_of_test();
	end
endmodule // exposure_start_trigger_ctrl_bench
`default_nettype wire
